/* core/hur_top.sv */
// hierarchical frame control, x2 upsampler and modulo reconstruction
// assumes markers arrive pre-classified, one per cycle, with their fields
`include "hur_defines.svh"
`timescale 1ns/1ps
`default_nettype none

module hur_fifo #(
  parameter int W = `HUR_SAMPLE_W + 1,
  parameter int D = `HUR_FIFO_DEPTH
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic ce_in,
  input wire logic in_valid_in,
  output logic in_ready_out,
  input wire logic [W-1:0] in_data_in,
  output logic out_valid_out,
  input wire logic out_ready_in,
  output logic [W-1:0] out_data_out
);
  localparam int PW = $clog2(D);
  localparam int CW = $clog2(D + 1);
  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [PW-1:0] wp;
    logic [PW-1:0] rp;
    logic [CW-1:0] cnt;
  } hur_fifo_s;
  hur_fifo_s q, d;
  logic push, pop;

  assign in_ready_out = (q.cnt != CW'(D));
  assign out_valid_out = (q.cnt != '0);
  assign out_data_out = q.mem[q.rp];

  always_comb begin
    d = q;
    push = in_valid_in && in_ready_out;
    pop = out_valid_out && out_ready_in;
    if (push) begin
      d.mem[q.wp] = in_data_in;
      d.wp = (q.wp == PW'(D - 1)) ? '0 : q.wp + PW'(1);
    end
    if (pop) begin
      d.rp = (q.rp == PW'(D - 1)) ? '0 : q.rp + PW'(1);
    end
    if (push && !pop) begin
      d.cnt = q.cnt + CW'(1);
    end else if (pop && !push) begin
      d.cnt = q.cnt - CW'(1);
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      q <= '0;
    end else if (ce_in) begin
      q <= d;
    end
  end
endmodule // hur_fifo

module hur_top #(
  parameter int SW = `HUR_SAMPLE_W,
  parameter int MAXW = `HUR_MAX_W,
  parameter int MAXH = `HUR_MAX_H,
  parameter int DEPTH = `HUR_FIFO_DEPTH,
  parameter int DW = $clog2(((MAXW > MAXH) ? MAXW : MAXH) + 1)
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic ce_in,
  input wire logic mk_valid_in,
  input wire hur_pkg::hur_mk_e mk_code_in,
  input wire logic exp_h_in,
  input wire logic exp_v_in,
  input wire logic sof_diff_in,
  input wire logic sof_lossless_in,
  input wire logic [DW-1:0] sof_width_in,
  input wire logic [DW-1:0] sof_height_in,
  input wire logic [2:0] pred_sel_in,
  input wire logic diff_valid_in,
  output logic diff_ready_out,
  input wire logic [SW-1:0] diff_data_in,
  output logic rec_valid_out,
  input wire logic rec_ready_in,
  output logic [SW-1:0] rec_data_out,
  output logic rec_last_out,
  output logic hier_out,
  output logic diff_path_out,
  output logic level_shift_en_out,
  output logic dc_pred_en_out,
  output logic [2:0] pred_sel_out,
  output logic [3:0] ac_max_cat_out,
  output logic busy_out,
  output logic frame_done_out,
  output logic err_out,
  output logic [2:0] err_code_out
);
  import hur_pkg::*;
  localparam int CAP = MAXW * MAXH;
  localparam int AW = $clog2(CAP);

  typedef struct packed {
    hur_st_e st;
    logic [1:0][CAP-1:0][SW-1:0] mem;
    logic bank;
    logic hier;
    logic first_done;
    logic exp_seen;
    logic exp_h;
    logic exp_v;
    logic fdiff;
    logic flossless;
    logic proc_lossless;
    logic final_seen;
    logic [2:0] pred;
    logic [DW-1:0] w;
    logic [DW-1:0] h;
    logic [DW-1:0] ow;
    logic [DW-1:0] oh;
    logic [DW-1:0] ox;
    logic [DW-1:0] oy;
    logic done;
    logic err;
    logic [2:0] err_code;
  } hur_top_s;

  hur_top_s q, d;
  logic fifo_ready;
  logic take;
  logic [SW-1:0] up;
  logic [SW-1:0] sum;
  logic is_last;
  logic [DW-1:0] nw;
  logic [DW-1:0] nh;
  logic [2:0] ecode;

  // horizontally expanded sample at reference row r, column hx
  function automatic logic [SW-1:0] hval(input logic [DW-1:0] r, input logic [DW-1:0] hx);
    logic [DW-1:0] k;
    logic [DW-1:0] k1;
    logic [AW-1:0] base;
    logic [SW:0] s;
    base = AW'(int'(r) * MAXW);
    k = q.exp_h ? (hx >> 1) : hx;
    k1 = ((k + DW'(1)) < q.w) ? k + DW'(1) : k;
    s = {1'b0, q.mem[q.bank][base + AW'(k)]} + {1'b0, q.mem[q.bank][base + AW'(k1)]};
    if (!q.exp_h || !hx[0]) begin
      hval = q.mem[q.bank][base + AW'(k)];
    end else begin
      hval = s[SW:1];
    end
  endfunction

  // vertical pass works on the horizontal result, never on raw rows
  function automatic logic [SW-1:0] uval(input logic [DW-1:0] vy, input logic [DW-1:0] hx);
    logic [DW-1:0] k;
    logic [DW-1:0] k1;
    logic [SW:0] s;
    k = q.exp_v ? (vy >> 1) : vy;
    k1 = ((k + DW'(1)) < q.h) ? k + DW'(1) : k;
    s = {1'b0, hval(k, hx)} + {1'b0, hval(k1, hx)};
    if (!q.exp_v || !vy[0]) begin
      uval = hval(k, hx);
    end else begin
      uval = s[SW:1];
    end
  endfunction

  hur_fifo #(
    .W(SW + 1),
    .D(DEPTH)
  ) u_fifo (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .ce_in(ce_in),
    .in_valid_in(take),
    .in_ready_out(fifo_ready),
    .in_data_in({is_last, sum}),
    .out_valid_out(rec_valid_out),
    .out_ready_in(rec_ready_in),
    .out_data_out({rec_last_out, rec_data_out})
  );

  // stalls the sample source while the buffer is full
  assign diff_ready_out = (q.st == HUR_RECON) && fifo_ready && ce_in;
  assign take = diff_valid_in && diff_ready_out;
  assign is_last = (q.ox == q.ow - DW'(1)) && (q.oy == q.oh - DW'(1));
  // always_comb so that the reference store read inside the functions is in the sensitivity
  always_comb begin
    up = '0;
    if (q.fdiff) begin
      up = uval(q.oy, q.ox);
    end
  end
  assign sum = up + diff_data_in;

  assign hier_out = q.hier;
  assign diff_path_out = q.fdiff;
  assign level_shift_en_out = !q.fdiff;
  assign dc_pred_en_out = !q.fdiff;
  assign pred_sel_out = q.pred;
  assign ac_max_cat_out = q.fdiff ? `HUR_AC_CAT_DIFF : `HUR_AC_CAT_BASE;
  assign busy_out = (q.st != HUR_IDLE);
  assign frame_done_out = q.done;
  assign err_out = q.err;
  assign err_code_out = q.err_code;

  always_comb begin
    d = q;
    d.done = 1'b0;
    ecode = `HUR_ERR_NONE;
    nw = q.exp_h ? DW'({q.w, 1'b0}) : q.w;
    nh = q.exp_v ? DW'({q.h, 1'b0}) : q.h;
    case (q.st)
      HUR_IDLE: begin
        // markers are only looked at between frames
        if (mk_valid_in) begin
          case (mk_code_in)
            HUR_MK_DHP: begin
              if (q.first_done) begin
                ecode = `HUR_ERR_DHP_LATE;
              end else begin
                d.hier = 1'b1;
              end
            end
            HUR_MK_EXP: begin
              if (q.exp_seen) begin
                ecode = `HUR_ERR_EXP_DUP;
              end else begin
                d.exp_seen = 1'b1;
                d.exp_h = exp_h_in;
                d.exp_v = exp_v_in;
              end
            end
            HUR_MK_SOF: begin
              d.exp_seen = 1'b0;
              if (!sof_diff_in) begin
                if (q.exp_seen) begin
                  ecode = `HUR_ERR_EXP_NONDIFF;
                end else if (sof_width_in == '0 || sof_height_in == '0 ||
                             sof_width_in > DW'(MAXW) || sof_height_in > DW'(MAXH)) begin
                  ecode = `HUR_ERR_SIZE;
                end else begin
                  if (!q.first_done) begin
                    d.proc_lossless = sof_lossless_in;
                  end
                  d.ow = sof_width_in;
                  d.oh = sof_height_in;
                  d.exp_h = 1'b0;
                  d.exp_v = 1'b0;
                end
              end else begin
                if (!q.first_done) begin
                  ecode = `HUR_ERR_DIFF_FIRST;
                end else if (q.proc_lossless && !sof_lossless_in) begin
                  ecode = `HUR_ERR_PROC_MIX;
                end else if (!q.proc_lossless && q.final_seen) begin
                  ecode = `HUR_ERR_PROC_MIX;
                end else if (q.exp_seen && ((q.exp_h && q.w > DW'(MAXW / 2)) ||
                             (q.exp_v && q.h > DW'(MAXH / 2)))) begin
                  ecode = `HUR_ERR_SIZE;
                end else begin
                  if (!q.exp_seen) begin
                    d.exp_h = 1'b0;
                    d.exp_v = 1'b0;
                    d.ow = q.w;
                    d.oh = q.h;
                  end else begin
                    d.ow = nw;
                    d.oh = nh;
                  end
                  if (sof_lossless_in && !q.proc_lossless) begin
                    d.final_seen = 1'b1;
                  end
                end
              end
              if (ecode == `HUR_ERR_NONE) begin
                d.st = HUR_RECON;
                d.fdiff = sof_diff_in;
                d.flossless = sof_lossless_in;
                d.pred = sof_diff_in ? `HUR_PRED_DIFF : pred_sel_in;
                d.ox = '0;
                d.oy = '0;
              end
            end
            HUR_MK_EOI, HUR_MK_SOI: begin
              d.hier = 1'b0;
              d.first_done = 1'b0;
              d.exp_seen = 1'b0;
              d.final_seen = 1'b0;
              d.fdiff = 1'b0;
              d.err = 1'b0;
              d.err_code = `HUR_ERR_NONE;
            end
            default: begin
            end
          endcase
        end
      end
      HUR_RECON: begin
        if (take) begin
          d.mem[!q.bank][AW'(int'(q.oy) * MAXW + int'(q.ox))] = sum;
          if (q.ox == q.ow - DW'(1)) begin
            d.ox = '0;
            d.oy = q.oy + DW'(1);
          end else begin
            d.ox = q.ox + DW'(1);
          end
          if (is_last) begin
            d.st = HUR_DONE;
          end
        end
      end
      HUR_DONE: begin
        // swap banks: the sums become the references of the next frame
        d.bank = !q.bank;
        d.w = q.ow;
        d.h = q.oh;
        d.first_done = 1'b1;
        d.done = 1'b1;
        d.st = HUR_IDLE;
      end
      default: begin
        d.st = HUR_IDLE;
      end
    endcase
    // first error is kept until SOI or EOI
    if (ecode != `HUR_ERR_NONE && !q.err) begin
      d.err = 1'b1;
      d.err_code = ecode;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      q <= '0;
    end else if (ce_in) begin
      q <= d;
    end
  end
endmodule // hur_top

`default_nettype wire

/* core/hur_defines.svh */
// constants of the hierarchical upsample / reconstruct block
// assumes nothing; included by the top module only, not by the package
`ifndef HUR_DEFINES_SVH
`define HUR_DEFINES_SVH
`define HUR_SAMPLE_W 16
`define HUR_MAX_W 8
`define HUR_MAX_H 8
`define HUR_FIFO_DEPTH 32
`define HUR_AC_CAT_DIFF 4'hf
`define HUR_AC_CAT_BASE 4'he
`define HUR_PRED_DIFF 3'h0
`define HUR_ERR_NONE 3'h0
`define HUR_ERR_DHP_LATE 3'h1
`define HUR_ERR_EXP_DUP 3'h2
`define HUR_ERR_DIFF_FIRST 3'h3
`define HUR_ERR_PROC_MIX 3'h4
`define HUR_ERR_SIZE 3'h5
`define HUR_ERR_EXP_NONDIFF 3'h6
`endif

/* core/hur_pkg.sv */
// types of the hierarchical upsample / reconstruct block
// assumes the marker parser outside has already classified each marker
package hur_pkg;
  typedef enum logic [2:0] {
    HUR_MK_OTHER = 3'h0,
    HUR_MK_DHP = 3'h1,
    HUR_MK_EXP = 3'h2,
    HUR_MK_SOF = 3'h3,
    HUR_MK_EOI = 3'h4,
    HUR_MK_SOI = 3'h5
  } hur_mk_e;
  typedef enum logic [1:0] {
    HUR_IDLE = 2'b00,
    HUR_RECON = 2'b01,
    HUR_DONE = 2'b11
  } hur_st_e;
endpackage

/* bench/hur_top_props.sv */
// port checker for hur_top
// assumes one clock domain; bound onto every hur_top
`timescale 1ns/1ps
`default_nettype none
module hur_top_chk (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic ce_in,
  input wire logic mk_valid_in,
  input wire hur_pkg::hur_mk_e mk_code_in,
  input wire logic sof_diff_in,
  input wire logic rec_valid_out,
  input wire logic rec_ready_in,
  input wire logic [15:0] rec_data_out,
  input wire logic hier_out,
  input wire logic diff_path_out,
  input wire logic level_shift_en_out,
  input wire logic dc_pred_en_out,
  input wire logic [2:0] pred_sel_out,
  input wire logic [3:0] ac_max_cat_out,
  input wire logic busy_out,
  input wire logic err_out,
  input wire logic [2:0] err_code_out
);
  import hur_pkg::*;
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  sequence take(hur_mk_e c);
    ce_in && mk_valid_in && !busy_out && mk_code_in == c;
  endsequence
  sequence soi_then(hur_mk_e c);
    take(HUR_MK_SOI) ##1 take(c);
  endsequence
  shift_off_a: assert property (
    level_shift_en_out != diff_path_out && dc_pred_en_out != diff_path_out)
    else $error("shift or dc predict wrong");
  ac_cat_a: assert property (
    ac_max_cat_out == (diff_path_out ? 4'hf : 4'he))
    else $error("ac category wrong");
  pred_zero_a: assert property (diff_path_out |-> pred_sel_out == 3'h0)
    else $error("predictor not zero");
  soi_clear_a: assert property (take(HUR_MK_SOI) |=> !hier_out && !err_out)
    else $error("start not cleared");
  hier_set_a: assert property (soi_then(HUR_MK_DHP) |=> hier_out)
    else $error("hier flag not set");
  diff_first_a: assert property (
    soi_then(HUR_MK_SOF) ##0 sof_diff_in |=> err_out && err_code_out == 3'h3 && !busy_out)
    else $error("diff first accepted");
  exp_dup_a: assert property (take(HUR_MK_EXP) ##1 take(HUR_MK_EXP) |=> err_out)
    else $error("second expand accepted");
  out_hold_a: assert property (
    rec_valid_out && !rec_ready_in |=> rec_valid_out && $stable(rec_data_out))
    else $error("output dropped");
  frame_kind_a: assert property (
    take(HUR_MK_SOF) ##1 busy_out |-> diff_path_out == $past(sof_diff_in))
    else $error("frame kind not taken");
endmodule // hur_top_chk
bind hur_top hur_top_chk chk_i (
  .clk_in(clk_in),
  .rst_n_in(rst_n_in),
  .ce_in(ce_in),
  .mk_valid_in(mk_valid_in),
  .mk_code_in(mk_code_in),
  .sof_diff_in(sof_diff_in),
  .rec_valid_out(rec_valid_out),
  .rec_ready_in(rec_ready_in),
  .rec_data_out(rec_data_out),
  .hier_out(hier_out),
  .diff_path_out(diff_path_out),
  .level_shift_en_out(level_shift_en_out),
  .dc_pred_en_out(dc_pred_en_out),
  .pred_sel_out(pred_sel_out),
  .ac_max_cat_out(ac_max_cat_out),
  .busy_out(busy_out),
  .err_out(err_out),
  .err_code_out(err_code_out)
);
`default_nettype wire

/* bench/hur_src.sv */
// difference source standing in for the entropy decoder
// assumes the bench fills q; changes only on falling edges
`timescale 1ns/1ps
`default_nettype none
module hur_src (
  input wire logic clk_in,
  input wire logic ready_in,
  output logic valid_out = 1'b0,
  output logic [15:0] data_out = 16'h0000
);
  logic [15:0] q[$];
  bit took = 0;
  always @(posedge clk_in) took = valid_out && ready_in;
  always @(negedge clk_in) begin
    if (took) void'(q.pop_front());
    if (!valid_out || took) begin
      // random gaps; idle data toggles so stale values never match
      valid_out = q.size() > 0 && $urandom_range(3) != 0;
      data_out = valid_out ? q[0] : ~data_out;
    end
  end
endmodule // hur_src
`default_nettype wire

/* bench/hur_top_tb.sv */
// self-checking bench of hur_top against a queue model
// assumes hur_src feeds samples and the checker is bound in
`timescale 1ns/1ps
`default_nettype none
module hur_top_tb;
  import hur_pkg::*;
  logic clk_in = 0, rst_n_in = 0, ce_in = 1, mk_valid_in = 0, stall = 0;
  logic exp_h_in = 0, exp_v_in = 0, sof_diff_in = 0, sof_lossless_in = 0;
  logic rec_ready_in = 0, diff_valid_in, diff_ready_out, rec_valid_out, rec_last_out;
  logic hier_out, diff_path_out, level_shift_en_out, dc_pred_en_out, busy_out;
  logic frame_done_out, err_out;
  hur_mk_e mk_code_in = HUR_MK_OTHER;
  logic [3:0] sof_width_in = 4'h0, sof_height_in = 4'h0, ac_max_cat_out;
  logic [2:0] pred_sel_in = 3'h5, pred_sel_out, err_code_out;
  logic [15:0] diff_data_in, rec_data_out;
  int fail_count = 0, checks = 0, rw, rh, e, nd = 0, rf[$], eq[$];
  always #12.5 clk_in = ~clk_in;
  hur_src src (.clk_in(clk_in), .ready_in(diff_ready_out), .valid_out(diff_valid_in),
    .data_out(diff_data_in));
  hur_top uut (.*);
  task automatic cmp_smp(string n, logic [16:0] x, logic [16:0] g);
    checks++;
    if (g !== x) begin
      fail_count++;
      $display("Error %s expected %h seen %h", n, x, g);
    end
  endtask
  task automatic cmp_st(logic [2:0] x);
    checks++;
    if ({err_out, err_code_out} !== {x != 3'h0, x}) begin
      fail_count++;
      $display("Error err expected %h seen %h", {x != 3'h0, x}, {err_out, err_code_out});
    end
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic mk(hur_mk_e c, logic [3:0] f = 4'h0, logic [3:0] w = 4'h1);
    {exp_h_in, exp_v_in, sof_diff_in, sof_lossless_in} = f;
    mk_code_in = c;
    {sof_width_in, sof_height_in, mk_valid_in} = {w, rh[3:0], 1'b1};
    @(negedge clk_in);
  endtask
  task automatic mk_end();
    mk_valid_in = 0;
    @(negedge clk_in);
  endtask
  function automatic int at(int x, int y);
    return rf[(y < rh ? y : rh - 1) * rw + (x < rw ? x : rw - 1)];
  endfunction
  function automatic void ups(bit h, bit v);
    int t[$];
    if (h) begin
      for (int y = 0; y < rh; y++)
        for (int x = 0; x < 2 * rw; x++)
          t.push_back((at(x / 2, y) + at(x / 2 + x % 2, y)) / 2);
      rf = t;
      rw *= 2;
    end
    if (v) begin
      t = {};
      for (int y = 0; y < 2 * rh; y++)
        for (int x = 0; x < rw; x++)
          t.push_back((at(x, y / 2) + at(x, y / 2 + y % 2)) / 2);
      rf = t;
      rh *= 2;
    end
  endfunction
  task automatic frame(bit base);
    int d, n;
    n = nd;
    if (base) rf = {};
    if (base) repeat (rw * rh) rf.push_back(0);
    foreach (rf[i]) begin
      d = $urandom & 32'h0000_ffff;
      src.q.push_back(d[15:0]);
      rf[i] = (rf[i] + d) & 32'h0000_ffff;
      eq.push_back(rf[i]);
    end
    repeat (4000) if (eq.size() > 0 || busy_out) @(negedge clk_in);
    if (eq.size() > 0 || busy_out) begin
      fail_count++;
      conclude();
    end
    // one more edge so the done pulse is counted before looking
    @(negedge clk_in);
    cmp_smp("frame_done", 17'h0_0001, 17'(nd - n));
  endtask
  always @(negedge clk_in) if (frame_done_out === 1'b1) nd++;
  always @(negedge clk_in) rec_ready_in <= !stall && $urandom_range(3) != 0;
  always @(posedge clk_in) if (rec_valid_out === 1'b1 && rec_ready_in) begin
    e = eq.size() > 0 ? eq.pop_front() : -1;
    cmp_smp("rec", {eq.size() == 0, e[15:0]}, {rec_last_out, rec_data_out});
  end
  initial begin
    void'($urandom(32'h0000_2709));
    repeat (10) @(negedge clk_in);
    rst_n_in = 1;
    cmp_smp("status", 17'h0_003c, {11'h000, level_shift_en_out, ac_max_cat_out, hier_out});
    rw = 2;
    rh = 3;
    mk(HUR_MK_SOI);
    mk(HUR_MK_DHP);
    mk(HUR_MK_SOF, 4'h0, 4'h2);
    mk_end();
    cmp_smp("base", 17'h0_001a, {12'h000, hier_out, pred_sel_out, diff_path_out});
    frame(1);
    $display("test base frame done");
    mk(HUR_MK_EXP, 4'hc);
    mk(HUR_MK_SOF, 4'h2);
    mk_end();
    cmp_smp("diff", 17'h0_0001, {13'h0000, pred_sel_out, diff_path_out});
    ups(1, 1);
    frame(0);
    $display("test both directions done");
    mk(HUR_MK_EXP, 4'h8);
    mk(HUR_MK_SOF, 4'h2);
    mk_end();
    ups(1, 0);
    stall = 1;
    fork
      frame(0);
      begin
        repeat (120) @(negedge clk_in);
        cmp_smp("ready_full", 17'h0_0000, {16'h0000, diff_ready_out});
        stall = 0;
      end
    join
    $display("test horizontal with full buffer done");
    mk(HUR_MK_DHP);
    mk_end();
    cmp_st(3'h1);
    mk(HUR_MK_SOI);
    mk(HUR_MK_EXP);
    mk(HUR_MK_EXP);
    mk_end();
    cmp_st(3'h2);
    mk(HUR_MK_SOI);
    mk(HUR_MK_SOF, 4'h2);
    mk_end();
    cmp_st(3'h3);
    for (int k = 0; k < 2; k++) begin
      rw = 1;
      rh = 1;
      mk(HUR_MK_SOI);
      mk(HUR_MK_DHP);
      mk(HUR_MK_SOF, k ? 4'h0 : 4'h1);
      mk_end();
      frame(1);
      if (k) mk(HUR_MK_SOF, 4'h3);
      if (k) mk_end();
      if (k) frame(0);
      mk(HUR_MK_SOF, 4'h2);
      mk_end();
      cmp_st(3'h4);
    end
    $display("test order errors done");
    conclude();
  end
endmodule // hur_top_tb
`default_nettype wire
